/* include/actcfg_params.svh */
// Offsets, field positions, reset values and decode constants for the
// channel-two configuration register bank.
// Assumes an 8-bit control port with a 7-bit register address.
`ifndef ACTCFG_PARAMS_SVH
`define ACTCFG_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ACTCFG_ADDR_INPUT_SETUP 7'h41
`define ACTCFG_ADDR_GAIN 7'h42
`define ACTCFG_ADDR_VOLUME 7'h43
`define ACTCFG_ADDR_GAIN_TRIM 7'h44

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ACTCFG_RST_INPUT_SETUP 8'h00
`define ACTCFG_RST_GAIN 8'h00
`define ACTCFG_RST_VOLUME 8'hC9
`define ACTCFG_RST_GAIN_TRIM 8'h80

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ACTCFG_KIND_BIT 7
`define ACTCFG_SRC_MSB 6
`define ACTCFG_SRC_LSB 5
`define ACTCFG_COUPLING_BIT 4
`define ACTCFG_IMP_MSB 3
`define ACTCFG_IMP_LSB 2
`define ACTCFG_SETUP_RSVD_BIT 1
`define ACTCFG_DYN_BIT 0
`define ACTCFG_GAIN_MSB 7
`define ACTCFG_GAIN_LSB 1
`define ACTCFG_SIGN_BIT 0
`define ACTCFG_TRIM_MSB 7
`define ACTCFG_TRIM_LSB 4

// ----------------------------------------------------------------------
// Decode limits
// ----------------------------------------------------------------------
`define ACTCFG_GAIN_MAX_CODE 7'h54
`define ACTCFG_VOL_UNITY_CODE 8'hC9
`define ACTCFG_TRIM_UNITY_CODE 4'h8
`define ACTCFG_SETUP_WMASK 8'hFD
`define ACTCFG_TRIM_WMASK 8'hF0

`endif

/* include/actcfg_pkg.sv */
// Types shared by the channel-two configuration bank.
// Assumes nothing beyond the params header.
package actcfg_pkg;

  // Input source selection
  typedef enum logic [1:0] {
    ACTCFG_SRC_ANALOG_DIFF = 2'b00,
    ACTCFG_SRC_ANALOG_SE = 2'b01,
    ACTCFG_SRC_DIGITAL_MIC = 2'b10,
    ACTCFG_SRC_RESERVED = 2'b11
  } actcfg_source_t;

  // Typical input impedance selection
  typedef enum logic [1:0] {
    ACTCFG_IMP_2K5 = 2'b00,
    ACTCFG_IMP_10K = 2'b01,
    ACTCFG_IMP_20K = 2'b10,
    ACTCFG_IMP_RESERVED = 2'b11
  } actcfg_impedance_t;

endpackage

/* rtl/actcfg_decode.sv */
// Decoder from stored register fields to front-end and signal-path controls.
// Assumes all inputs come from registers on the same clock.
`timescale 1ns/100ps
`include "actcfg_params.svh"

module actcfg_decode
  import actcfg_pkg::*;
(
  input wire logic [1:0] source_code,
  input wire logic coupling_raw,
  input wire logic [1:0] impedance_code,
  input wire logic [6:0] gain_code,
  input wire logic gain_sign,
  input wire logic [7:0] volume_code,
  output logic analog_selected,
  output logic digital_mic_selected,
  output logic coupling_effective,
  output logic [1:0] impedance_effective,
  output logic gain_code_legal,
  output logic negative_gain_allowed,
  output logic volume_muted,
  output logic config_fault
);

  // ----------------------------------------------------------------------
  // Source and front-end decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    analog_selected = (source_code == ACTCFG_SRC_ANALOG_DIFF) ||
                      (source_code == ACTCFG_SRC_ANALOG_SE);
    digital_mic_selected = (source_code == ACTCFG_SRC_DIGITAL_MIC);
    // Coupling and impedance mean nothing for the digital mic path
    coupling_effective = analog_selected & coupling_raw;
    impedance_effective = analog_selected ? impedance_code : 2'b00;
    gain_code_legal = (gain_code <= `ACTCFG_GAIN_MAX_CODE);
    // Negative gain only with the 10k or 20k settings
    negative_gain_allowed = (impedance_code == ACTCFG_IMP_10K) ||
                            (impedance_code == ACTCFG_IMP_20K);
    volume_muted = (volume_code == 8'h00);
    // Any reserved code or unsupported sign/impedance pairing
    config_fault = (source_code == ACTCFG_SRC_RESERVED) ||
                   (impedance_code == ACTCFG_IMP_RESERVED) ||
                   !gain_code_legal ||
                   (gain_sign && !negative_gain_allowed);
  end

endmodule // actcfg_decode

/* rtl/actcfg_regs.sv */
// Channel-two configuration register bank of a stereo audio ADC.
// Assumes a same-clock control port: write strobe, 7-bit address, 8-bit data.
`timescale 1ns/100ps
`include "actcfg_params.svh"

module actcfg_regs
  import actcfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_write, // One-cycle write strobe
  input wire logic reg_read, // One-cycle read strobe
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata, // Registered read data
  output logic reg_rvalid, // Pulse one cycle after reg_read
  output logic chan_two_input_kind,
  output logic [1:0] chan_two_source_select,
  output logic chan_two_coupling,
  output logic [1:0] chan_two_impedance,
  output logic chan_two_dynamics_enable,
  output logic [6:0] chan_two_analog_gain,
  output logic chan_two_gain_negative,
  output logic [7:0] chan_two_digital_volume,
  output logic [3:0] chan_two_gain_trim_code,
  output logic chan_two_analog_selected,
  output logic chan_two_digital_mic_selected,
  output logic chan_two_volume_muted,
  output logic chan_two_config_fault
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0] chan_two_input_setup; // Input type, source, coupling, etc.
  logic [7:0] chan_two_gain; // Gain code and sign
  logic [7:0] chan_two_volume; // Digital volume
  logic [7:0] chan_two_gain_trim; // Trim in upper nibble
  logic dec_analog;
  logic dec_digital;
  logic dec_coupling;
  logic [1:0] dec_impedance;
  logic dec_gain_legal;
  logic dec_neg_allowed;
  logic dec_muted;
  logic dec_fault;
  logic [7:0] next_rdata;

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  // Read-only bits are masked so a careless writer cannot set them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_two_input_setup <= `ACTCFG_RST_INPUT_SETUP;
      chan_two_gain <= `ACTCFG_RST_GAIN;
      chan_two_volume <= `ACTCFG_RST_VOLUME;
      chan_two_gain_trim <= `ACTCFG_RST_GAIN_TRIM;
    end
    else if (reg_write)
    begin
      unique case (reg_addr)
        `ACTCFG_ADDR_INPUT_SETUP:
          chan_two_input_setup <= reg_wdata & `ACTCFG_SETUP_WMASK;
        `ACTCFG_ADDR_GAIN:
          chan_two_gain <= reg_wdata;
        `ACTCFG_ADDR_VOLUME:
          chan_two_volume <= reg_wdata;
        `ACTCFG_ADDR_GAIN_TRIM:
          chan_two_gain_trim <= reg_wdata & `ACTCFG_TRIM_WMASK;
        default:
        begin
          // Other addresses belong to other banks
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read-back mux
  // ----------------------------------------------------------------------
  always_comb
  begin
    unique case (reg_addr)
      `ACTCFG_ADDR_INPUT_SETUP: next_rdata = chan_two_input_setup;
      `ACTCFG_ADDR_GAIN: next_rdata = chan_two_gain;
      `ACTCFG_ADDR_VOLUME: next_rdata = chan_two_volume;
      `ACTCFG_ADDR_GAIN_TRIM: next_rdata = chan_two_gain_trim;
      default: next_rdata = 8'h00; // Unmapped reads as zero
    endcase
  end

  // Read data registered so outputs come from flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_read;
      if (reg_read)
      begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  actcfg_decode u_decode (
    .source_code (chan_two_input_setup[`ACTCFG_SRC_MSB:`ACTCFG_SRC_LSB]),
    .coupling_raw (chan_two_input_setup[`ACTCFG_COUPLING_BIT]),
    .impedance_code (chan_two_input_setup[`ACTCFG_IMP_MSB:`ACTCFG_IMP_LSB]),
    .gain_code (chan_two_gain[`ACTCFG_GAIN_MSB:`ACTCFG_GAIN_LSB]),
    .gain_sign (chan_two_gain[`ACTCFG_SIGN_BIT]),
    .volume_code (chan_two_volume),
    .analog_selected (dec_analog),
    .digital_mic_selected (dec_digital),
    .coupling_effective (dec_coupling),
    .impedance_effective (dec_impedance),
    .gain_code_legal (dec_gain_legal),
    .negative_gain_allowed (dec_neg_allowed),
    .volume_muted (dec_muted),
    .config_fault (dec_fault)
  );

  // ----------------------------------------------------------------------
  // Control outputs to front end and signal path
  // ----------------------------------------------------------------------
  // One cycle behind the stored fields; harmless for static settings,
  // and it keeps every output on a flop.
  // Reset values match what the stored registers decode to at reset,
  // so no output glitches on the first edge after release.

  // Front-end controls: input type, source, coupling, impedance
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_two_input_kind <= 1'b0;
      chan_two_source_select <= 2'b00;
      chan_two_coupling <= 1'b0;
      chan_two_impedance <= 2'b00;
      chan_two_dynamics_enable <= 1'b0;
    end
    else
    begin
      chan_two_input_kind <= chan_two_input_setup[`ACTCFG_KIND_BIT];
      chan_two_source_select <= chan_two_input_setup[`ACTCFG_SRC_MSB:`ACTCFG_SRC_LSB];
      chan_two_coupling <= dec_coupling;
      chan_two_impedance <= dec_impedance;
      // Only the enable lives here; the function it enables is chosen elsewhere
      chan_two_dynamics_enable <= chan_two_input_setup[`ACTCFG_DYN_BIT];
    end
  end

  // Analog channel gain and its sign
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_two_analog_gain <= 7'h00;
      chan_two_gain_negative <= 1'b0;
    end
    else
    begin
      // Reserved gain codes clamp to the top step rather than overdrive
      chan_two_analog_gain <= dec_gain_legal ?
        chan_two_gain[`ACTCFG_GAIN_MSB:`ACTCFG_GAIN_LSB] :
        `ACTCFG_GAIN_MAX_CODE;
      // Sign honoured only where the front end supports it
      chan_two_gain_negative <= chan_two_gain[`ACTCFG_SIGN_BIT] & dec_neg_allowed;
    end
  end

  // Digital level: volume, mute flag and gain trim
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_two_digital_volume <= `ACTCFG_VOL_UNITY_CODE;
      chan_two_gain_trim_code <= `ACTCFG_TRIM_UNITY_CODE;
      chan_two_volume_muted <= 1'b0;
    end
    else
    begin
      chan_two_digital_volume <= chan_two_volume;
      chan_two_gain_trim_code <=
        chan_two_gain_trim[`ACTCFG_TRIM_MSB:`ACTCFG_TRIM_LSB];
      chan_two_volume_muted <= dec_muted;
    end
  end

  // Source status flags and the configuration fault summary
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_two_analog_selected <= 1'b1;
      chan_two_digital_mic_selected <= 1'b0;
      chan_two_config_fault <= 1'b0;
    end
    else
    begin
      // Pin muxing is software's job; these flags let it be checked
      chan_two_analog_selected <= dec_analog;
      chan_two_digital_mic_selected <= dec_digital;
      // Fault only reports; the stored codes are never altered by it
      chan_two_config_fault <= dec_fault;
    end
  end

endmodule // actcfg_regs

/* sim/actcfg_regs_properties.sv */
// Port checker for the channel-two configuration bank.
// Assumes the bank's own port names; bound in at the foot of this file.
`timescale 1ns/100ps
module actcfg_regs_properties
  import actcfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic chan_two_input_kind,
  input wire logic [1:0] chan_two_source_select,
  input wire logic chan_two_coupling,
  input wire logic [1:0] chan_two_impedance,
  input wire logic chan_two_dynamics_enable,
  input wire logic [6:0] chan_two_analog_gain,
  input wire logic chan_two_gain_negative,
  input wire logic [7:0] chan_two_digital_volume,
  input wire logic chan_two_analog_selected,
  input wire logic chan_two_digital_mic_selected,
  input wire logic chan_two_volume_muted,
  input wire logic chan_two_config_fault
);
  // ----------------------------------------------------------------
  // One clock domain, so clocking and reset are declared once
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Every read strobe gets exactly one valid pulse a cycle later
  chk_read_valid_pulse: assert property (reg_rvalid == $past(reg_read))
    else $error("read valid does not follow read strobe");
  chk_setup_reserved_zero: assert property (
    reg_read && reg_addr == 7'h41 |=> reg_rdata[1] == 1'b0)
    else $error("setup reserved bit read as one");
  chk_trim_reserved_zero: assert property (
    reg_read && reg_addr == 7'h44 |=> reg_rdata[3:0] == 4'h0)
    else $error("trim reserved bits read nonzero");
  chk_volume_follows_write: assert property (
    reg_write && reg_addr == 7'h43 |-> ##2 chan_two_digital_volume == $past(reg_wdata, 2))
    else $error("volume output does not follow write");
  chk_setup_follows_write: assert property (
    reg_write && reg_addr == 7'h41 |-> ##2 {chan_two_input_kind, chan_two_source_select,
    chan_two_dynamics_enable} == {$past(reg_wdata[7:5], 2), $past(reg_wdata[0], 2)})
    else $error("setup fields do not follow write");
  chk_source_decode: assert property (
    chan_two_analog_selected == !chan_two_source_select[1] &&
    chan_two_digital_mic_selected == (chan_two_source_select == 2'h2))
    else $error("source flags disagree with source field");
  chk_analog_only_fields: assert property (
    !chan_two_analog_selected |-> !chan_two_coupling && chan_two_impedance == 2'h0)
    else $error("coupling or impedance active without analog source");
  chk_gain_code_legal: assert property (chan_two_analog_gain <= 7'h54)
    else $error("gain output beyond top code");
  chk_sign_needs_imp: assert property (
    chan_two_gain_negative && chan_two_analog_selected |-> chan_two_impedance inside {2'h1, 2'h2})
    else $error("negative gain with unsupported impedance");
  chk_mute_flag: assert property (
    chan_two_volume_muted == (chan_two_digital_volume == 8'h00))
    else $error("mute flag disagrees with volume code");
  chk_reserved_source_fault: assert property (
    chan_two_source_select == 2'h3 |-> chan_two_config_fault)
    else $error("reserved source not flagged as fault");
  // Main scenarios reached
  cover property (chan_two_volume_muted);
  cover property (chan_two_gain_negative);
  cover property (chan_two_digital_mic_selected);
  cover property (chan_two_config_fault);
endmodule // actcfg_regs_properties

bind actcfg_regs actcfg_regs_properties props_i (
  .clk (clk),
  .rst_n (rst_n),
  .reg_write (reg_write),
  .reg_read (reg_read),
  .reg_addr (reg_addr),
  .reg_wdata (reg_wdata),
  .reg_rdata (reg_rdata),
  .reg_rvalid (reg_rvalid),
  .chan_two_input_kind (chan_two_input_kind),
  .chan_two_source_select (chan_two_source_select),
  .chan_two_coupling (chan_two_coupling),
  .chan_two_impedance (chan_two_impedance),
  .chan_two_dynamics_enable (chan_two_dynamics_enable),
  .chan_two_analog_gain (chan_two_analog_gain),
  .chan_two_gain_negative (chan_two_gain_negative),
  .chan_two_digital_volume (chan_two_digital_volume),
  .chan_two_analog_selected (chan_two_analog_selected),
  .chan_two_digital_mic_selected (chan_two_digital_mic_selected),
  .chan_two_volume_muted (chan_two_volume_muted),
  .chan_two_config_fault (chan_two_config_fault)
);

/* sim/actcfg_regs_tb.sv */
// Self-checking bench for the channel-two configuration bank.
// Assumes the port checker is bound in from its own file.
`timescale 1ns/100ps
module actcfg_regs_tb;
  import actcfg_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk, rst_n, reg_write, reg_read, reg_rvalid;
  logic [6:0] reg_addr, chan_two_analog_gain;
  logic [7:0] reg_wdata, reg_rdata, chan_two_digital_volume;
  logic chan_two_input_kind, chan_two_coupling, chan_two_dynamics_enable;
  logic chan_two_gain_negative, chan_two_analog_selected, chan_two_digital_mic_selected;
  logic chan_two_volume_muted, chan_two_config_fault;
  logic [1:0] chan_two_source_select, chan_two_impedance;
  logic [3:0] chan_two_gain_trim_code;
  int n_errors, comparisons;
  actcfg_regs actcfg_regs_i (
    .clk (clk),
    .rst_n (rst_n),
    .reg_write (reg_write),
    .reg_read (reg_read),
    .reg_addr (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .reg_rvalid (reg_rvalid),
    .chan_two_input_kind (chan_two_input_kind),
    .chan_two_source_select (chan_two_source_select),
    .chan_two_coupling (chan_two_coupling),
    .chan_two_impedance (chan_two_impedance),
    .chan_two_dynamics_enable (chan_two_dynamics_enable),
    .chan_two_analog_gain (chan_two_analog_gain),
    .chan_two_gain_negative (chan_two_gain_negative),
    .chan_two_digital_volume (chan_two_digital_volume),
    .chan_two_gain_trim_code (chan_two_gain_trim_code),
    .chan_two_analog_selected (chan_two_analog_selected),
    .chan_two_digital_mic_selected (chan_two_digital_mic_selected),
    .chan_two_volume_muted (chan_two_volume_muted),
    .chan_two_config_fault (chan_two_config_fault)
  );
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Byte compare, unknowns never match
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("Mismatches %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Write, then one more cycle so field outputs have settled
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_write = 1'b0;
    @(negedge clk);
  endtask
  // Read with a bounded wait for the valid pulse
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_read = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_read = 1'b0;
    for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++)
      @(negedge clk);
    if (reg_rvalid !== 1'b1)
    begin
      n_errors++;
      finish_test();
    end
    else
    begin
      check(reg_rdata, exp);
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(7'h41, 8'h00);
    rd(7'h42, 8'h00);
    rd(7'h43, 8'hC9);
    rd(7'h44, 8'h80);
    check({4'h0, chan_two_gain_trim_code}, 8'h08);
    // Reserved bit written as one must read back as zero
    wr(7'h41, 8'h9F);
    rd(7'h41, 8'h9D);
    check({3'h0, chan_two_input_kind, chan_two_coupling, chan_two_impedance,
      chan_two_dynamics_enable}, 8'h1F);
    // Every source code, coupling set; only the reserved code is a fault
    for (int s = 0; s < 4; s++)
    begin
      wr(7'h41, {1'b0, s[1:0], 5'b10100});
      check({6'h0, chan_two_source_select}, {6'h0, s[1:0]});
      check({6'h0, chan_two_analog_selected, chan_two_digital_mic_selected},
        {6'h0, s < 2, s == 2});
      check({7'h0, chan_two_coupling}, {7'h0, s < 2});
      check({7'h0, chan_two_config_fault}, {7'h0, s == 3});
    end
    // Every impedance code with negative top gain
    for (int m = 0; m < 4; m++)
    begin
      wr(7'h41, {4'h0, m[1:0], 2'h0});
      wr(7'h42, 8'hA9);
      check({6'h0, chan_two_impedance}, {6'h0, m[1:0]});
      check({chan_two_analog_gain, chan_two_gain_negative}, {7'h54, m == 1 || m == 2});
      check({7'h0, chan_two_config_fault}, {7'h0, m == 0 || m == 3});
    end
    // Reserved gain code stored but clamped at the output
    wr(7'h42, 8'hAA);
    rd(7'h42, 8'hAA);
    check({1'b0, chan_two_analog_gain}, 8'h54);
    wr(7'h43, 8'h00);
    check({7'h0, chan_two_volume_muted}, 8'h01);
    wr(7'h43, 8'hFF);
    check(chan_two_digital_volume, 8'hFF);
    check({7'h0, chan_two_volume_muted}, 8'h00);
    wr(7'h44, 8'hFF);
    rd(7'h44, 8'hF0);
    check({4'h0, chan_two_gain_trim_code}, 8'h0F);
    // Unmapped places hold nothing and disturb nothing
    wr(7'h45, 8'h55);
    rd(7'h45, 8'h00);
    rd(7'h40, 8'h00);
    rd(7'h41, 8'h0C);
    finish_test();
  end
endmodule // actcfg_regs_tb
